// file: imw_pkg.sv
package imw_pkg;
    // Clock and watchdog timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned WDOG_S = 4;
    localparam int unsigned WDOG_CYC = CLK_HZ * WDOG_S;

    // Register indexes, byte address is four times the index
    localparam logic [7:0] IDX_CTRL2 = 8'h02;
    localparam logic [7:0] IDX_MASK = 8'h03;
    localparam logic [7:0] IDX_SRC = 8'h04;
    localparam logic [7:0] IDX_DAA = 8'h05;

    // control_two fields
    localparam int CTL_PINSEL = 7;
    localparam int CTL_POL = 6;
    localparam int CTL_WDOG = 4;
    localparam int CTL_RINGBOTH = 2;
    localparam int CTL_HYB = 1;
    localparam int CTL_RX = 0;
    localparam logic [7:0] CTL2_WMASK = 8'hD7;

    // interrupt_mask and source flag positions
    localparam int SRC_RING = 7;
    localparam int SRC_OVL = 6;
    localparam int SRC_FRAME = 5;
    localparam int SRC_BILL = 4;
    localparam int SRC_DROP = 3;
    localparam int SRC_LOOP = 2;
    localparam int SRC_TIP = 1;
    localparam int SRC_POL = 0;
    localparam int OH_BIT = 0;
    localparam int LV_POL_BIT = 7;

    // Reset values
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] SRC_RST = 8'h00;
    localparam logic OH_RST = 1'b0;

    // Cycles after reset before edges are trusted
    localparam logic [1:0] ARM_CYC = 2'h3;
    localparam int LCS_W = 5;

    typedef enum logic [1:0] {
        RING_IDLE = 2'b00,
        RING_BURST = 2'b01,
        RING_CLEARED = 2'b10
    } imw_ring_e;

    typedef struct packed {
        logic ring;
        logic rx_ovl;
        logic frame_lost;
        logic billing;
        logic dropout;
        logic [LCS_W-1:0] loop_current_level;
        logic tip_ground_state;
        logic [7:0] line_voltage_level;
    } imw_line_s;
endpackage

// file: imw_sync.sv
module imw_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic mclk,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // Per-bit two-stage synchroniser, no reset so no glitch on release
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk) begin
            meta_q[i] <= d[i];
            q[i] <= meta_q[i];
        end
    end
endmodule

// file: imw_wdog.sv
module imw_wdog #(
    parameter int unsigned TIMEOUT = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic restart,
    output logic expire
);
    logic [31:0] cnt_q;

    always_ff @(posedge mclk) begin
        if (rst || restart || !enable) begin
            cnt_q <= 32'h0;
            expire <= 1'b0;
        end else if (cnt_q == 32'(TIMEOUT - 1)) begin
            cnt_q <= 32'h0;
            expire <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            expire <= 1'b0;
        end
    end

    a_wdog_restart_zero: assert property (
        @(posedge mclk) disable iff (rst)
        restart |=> (cnt_q == 32'h0) && !expire)
        else $error("watchdog not restarted by access");
endmodule

// file: imw_ctrl.sv
// The AHB-Lite register port was chosen for this implementation.
module imw_ctrl #(
    parameter int unsigned WDOG_CYCLES = imw_pkg::WDOG_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Line-side detector levels, asynchronous
    input wire imw_pkg::imw_line_s line_in,
    // Call progress and shared pin
    input wire logic progress_in,
    output logic progress_out_or_irq_pin,
    // Path and hook controls
    output logic hybrid_connect,
    output logic rx_path_on,
    output logic offhook_ctl
);
    import imw_pkg::*;

    function automatic logic reg_hit(
        input logic [31:0] a,
        input logic [7:0] idx
    );
        reg_hit = (a[31:2] == {22'h0, idx});
    endfunction

    imw_line_s line_s;
    imw_line_s line_p_q;
    imw_ring_e ring_st_q;
    logic [1:0] arm_q;
    logic armed;
    logic access;
    logic wr_q;
    logic [31:0] wr_addr_q;
    logic wr_ctl;
    logic wr_mask;
    logic wr_src;
    logic wr_daa;
    logic [7:0] ctl_q;
    logic [7:0] mask_q;
    logic [7:0] flags_q;
    logic [7:0] rd_byte;
    logic [7:0] src_set;
    logic [7:0] src_clr;
    logic ring_rise;
    logic ring_fall;
    logic ring_set;
    logic irq_pend;
    logic wd_expire;

    // Detector levels cross into the mclk domain
    imw_sync #(.W($bits(imw_line_s))) u_sync (
        .mclk(mclk),
        .d(line_in),
        .q(line_s)
    );

    // Register access watchdog
    imw_wdog #(.TIMEOUT(WDOG_CYCLES)) u_wdog (
        .mclk(mclk),
        .rst(rst),
        .enable(ctl_q[CTL_WDOG]),
        .restart(access),
        .expire(wd_expire)
    );

    // Bus transfer taken in the address phase
    assign access = hsel & hready & htrans[1];
    assign wr_ctl = wr_q & reg_hit(wr_addr_q, IDX_CTRL2);
    assign wr_mask = wr_q & reg_hit(wr_addr_q, IDX_MASK);
    assign wr_src = wr_q & reg_hit(wr_addr_q, IDX_SRC);
    assign wr_daa = wr_q & reg_hit(wr_addr_q, IDX_DAA);

    always_comb begin
        rd_byte = 8'h00;
        if (reg_hit(haddr, IDX_CTRL2)) begin
            rd_byte = ctl_q & CTL2_WMASK;
        end else if (reg_hit(haddr, IDX_MASK)) begin
            rd_byte = mask_q;
        end else if (reg_hit(haddr, IDX_SRC)) begin
            rd_byte = flags_q;
        end else if (reg_hit(haddr, IDX_DAA)) begin
            rd_byte = {7'h00, offhook_ctl};
        end
    end

    // Zero wait states; unmapped reads return zero, writes are dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= 1'b0;
            wr_addr_q <= 32'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_q <= access & hwrite;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (access) begin
                wr_addr_q <= haddr;
            end
            if (access && !hwrite) begin
                hrdata <= {24'h0, rd_byte};
            end
        end
    end

    // Control register; reserved bits never stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= CTL2_RST;
        end else if (wr_ctl) begin
            ctl_q <= hwdata[7:0] & CTL2_WMASK;
            ctl_q[CTL_WDOG] <= hwdata[CTL_WDOG] | ctl_q[CTL_WDOG];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mask_q <= MASK_RST;
        end else if (wr_mask) begin
            mask_q <= hwdata[7:0];
        end
    end

    // Software write wins over a coinciding timeout
    always_ff @(posedge mclk) begin
        if (rst) begin
            offhook_ctl <= OH_RST;
        end else if (wr_daa) begin
            offhook_ctl <= hwdata[OH_BIT];
        end else if (wd_expire) begin
            offhook_ctl <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hybrid_connect <= 1'b0;
            rx_path_on <= 1'b0;
        end else begin
            hybrid_connect <= ctl_q[CTL_HYB];
            rx_path_on <= ctl_q[CTL_RX];
        end
    end

    // Synchroniser and edge history settle before edges count
    always_ff @(posedge mclk) begin
        if (rst) begin
            arm_q <= 2'h0;
        end else if (arm_q != ARM_CYC) begin
            arm_q <= arm_q + 2'h1;
        end
    end
    assign armed = (arm_q == ARM_CYC);

    always_ff @(posedge mclk) begin
        if (rst) begin
            line_p_q <= '0;
        end else begin
            line_p_q <= line_s;
        end
    end

    assign ring_rise = armed & line_s.ring & ~line_p_q.ring;
    assign ring_fall = armed & ~line_s.ring & line_p_q.ring;

    // Tracks whether the start-of-burst flag was serviced
    always_ff @(posedge mclk) begin
        if (rst) begin
            ring_st_q <= RING_IDLE;
        end else begin
            case (ring_st_q)
                RING_IDLE: begin
                    if (ring_rise) begin
                        ring_st_q <= RING_BURST;
                    end
                end
                RING_BURST: begin
                    if (ring_fall) begin
                        ring_st_q <= RING_IDLE;
                    end else if (src_clr[SRC_RING]) begin
                        ring_st_q <= RING_CLEARED;
                    end
                end
                RING_CLEARED: begin
                    if (ring_fall) begin
                        ring_st_q <= RING_IDLE;
                    end
                end
                default: begin
                    ring_st_q <= RING_IDLE;
                end
            endcase
        end
    end

    assign ring_set = ring_rise |
        (ring_fall & (ring_st_q == RING_CLEARED) &
        ctl_q[CTL_RINGBOTH]);

    always_comb begin
        src_set = 8'h00;
        src_set[SRC_RING] = ring_set;
        src_set[SRC_OVL] = line_s.rx_ovl & ~line_p_q.rx_ovl;
        src_set[SRC_FRAME] = line_s.frame_lost;
        src_set[SRC_BILL] = line_s.billing & ~line_p_q.billing;
        src_set[SRC_DROP] = line_s.dropout & ~line_p_q.dropout;
        src_set[SRC_LOOP] = (&line_s.loop_current_level) &
            ~(&line_p_q.loop_current_level);
        src_set[SRC_TIP] = line_s.tip_ground_state &
            ~line_p_q.tip_ground_state;
        src_set[SRC_POL] = line_s.line_voltage_level[LV_POL_BIT] ^
            line_p_q.line_voltage_level[LV_POL_BIT];
        src_set = src_set & {8{armed}};
    end

    // Writing 0 clears a flag, writing 1 leaves it alone
    assign src_clr = wr_src ? ~hwdata[7:0] : 8'h00;

    // A new event in the clearing cycle keeps the flag set
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_q <= SRC_RST;
        end else begin
            flags_q <= (flags_q & ~src_clr) | src_set;
        end
    end

    // Each source gated by its own mask bit
    assign irq_pend = |(flags_q & mask_q);
    // Same gate serves

    always_ff @(posedge mclk) begin
        if (rst) begin
            progress_out_or_irq_pin <= 1'b0;
        end else if (ctl_q[CTL_PINSEL]) begin
            progress_out_or_irq_pin <=
                ~(irq_pend ^ ctl_q[CTL_POL]);
        end else begin
            progress_out_or_irq_pin <= progress_in;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_ring_serviced;
        (ring_st_q == RING_CLEARED) && ctl_q[CTL_RINGBOTH];
    endsequence

    sequence s_burst_ends;
        ring_fall;
    endsequence

    sequence s_burst_unserviced;
        (ring_st_q == RING_BURST) && !src_clr[SRC_RING];
    endsequence

    // Sampled rst skips the edge on which reset is released
    a_pin_progress_path: assert property (
        !rst && !ctl_q[CTL_PINSEL]
        |=> progress_out_or_irq_pin == $past(progress_in))
        else $error("pin not carrying call progress");

    a_pin_active_high: assert property (
        ctl_q[CTL_PINSEL] && ctl_q[CTL_POL]
        |=> progress_out_or_irq_pin == $past(irq_pend))
        else $error("active high interrupt level wrong");

    a_pin_active_low: assert property (
        ctl_q[CTL_PINSEL] && !ctl_q[CTL_POL]
        |=> progress_out_or_irq_pin == !$past(irq_pend))
        else $error("active low interrupt level wrong");

    a_mask_gates_pin: assert property (
        ctl_q[CTL_PINSEL] && ctl_q[CTL_POL] && ((flags_q & mask_q) == 8'h00)
        |=> !progress_out_or_irq_pin)
        else $error("interrupt without masked pending flag");

    a_wdog_sticky_bit: assert property (
        ctl_q[CTL_WDOG] |=> ctl_q[CTL_WDOG])
        else $error("watchdog enable cleared without reset");

    a_wdog_forces_onhook: assert property (
        wd_expire && !wr_daa |=> !offhook_ctl)
        else $error("watchdog timeout left line off-hook");

    a_offhook_rewrite: assert property (
        wr_daa && hwdata[OH_BIT] |=> offhook_ctl)
        else $error("off-hook write not taken");

    a_ring_start_flag: assert property (
        ring_rise |=> flags_q[SRC_RING] && ring_st_q == RING_BURST)
        else $error("ring start did not raise flag");

    a_ring_end_flag: assert property (
        s_ring_serviced ##0 s_burst_ends |=> flags_q[SRC_RING])
        else $error("ring end interrupt missing");

    a_ring_no_end_flag: assert property (
        s_burst_unserviced ##0 s_burst_ends
        |=> flags_q[SRC_RING] == $past(flags_q[SRC_RING]))
        else $error("ring end interrupt without service");

    a_flag_sticky: assert property (
        1'b1 |=> ($past(flags_q & ~src_clr) & ~flags_q) == 8'h00)
        else $error("source flag dropped without write of 0");
endmodule

// file: imw_line_model.sv
module imw_line_model (
    // Clock
    input wire logic mclk,
    // Event requests, one bit per source in flag order
    input wire logic [7:0] ev,
    // Detector levels toward the block
    output imw_pkg::imw_line_s line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import imw_pkg::*;

    // Registered so every level change lands just after an edge
    always_ff @(posedge mclk) begin
        line_in.ring <= ev[SRC_RING];
        line_in.rx_ovl <= ev[SRC_OVL];
        line_in.frame_lost <= ev[SRC_FRAME];
        line_in.billing <= ev[SRC_BILL];
        line_in.dropout <= ev[SRC_DROP];
        // Quiet loop level sits well below full scale
        line_in.loop_current_level <= ev[SRC_LOOP] ? 5'h1F : 5'h0A;
        line_in.tip_ground_state <= ev[SRC_TIP];
        // Both directions of bit 7 count as a reversal
        line_in.line_voltage_level <= {ev[SRC_POL], 7'h2A};
    end
endmodule

// file: irq_mask_watchdog_ctrl_tb.sv
module irq_mask_watchdog_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import imw_pkg::*;

    localparam logic [31:0] A_CTL = 32'(IDX_CTRL2) << 2;
    localparam logic [31:0] A_MASK = 32'(IDX_MASK) << 2;
    localparam logic [31:0] A_SRC = 32'(IDX_SRC) << 2;
    localparam logic [31:0] A_HOOK = 32'(IDX_DAA) << 2;
    localparam logic [31:0] A_BAD = 32'h0000_0040;

    logic mclk, rst, hsel, hwrite, hreadyout, hresp;
    logic progress_in = 1'b0;
    logic pin, hyb, rx, oh, pol;
    logic rd_ph = 1'b0;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] ev;
    logic [31:0] haddr, hwdata, hrdata, m, r, exp_v;
    logic [31:0] exp_q[$];
    imw_line_s line_in;
    int n_errors, n_checks, seed;

    imw_line_model u_line (.mclk(mclk), .ev(ev), .line_in(line_in));

    imw_ctrl #(.WDOG_CYCLES(20)) DUT (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in),
        .progress_in(progress_in), .progress_out_or_irq_pin(pin),
        .hybrid_connect(hyb), .rx_path_on(rx), .offhook_ctl(oh)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task wrdy;
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            $display("unexpected hready wait exp 1 got %b", hreadyout);
            end_sim();
        end
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wrdy();
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // The expected word is noted first; the monitor takes it off
    task rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task ring(input logic md);
        wr(A_CTL, {24'h0, 5'h18, md, 2'h0});
        wr(A_MASK, 32'h80);
        ev[SRC_RING] <= 1'b1;
        repeat (5) @(posedge mclk);
        wr(A_SRC, 32'h0);
        rd(A_SRC, 32'h0);
        #1 cmp("ring pin", 32'h0, {31'h0, pin});
        ev[SRC_RING] <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 cmp("ring end pin", {31'h0, md}, {31'h0, pin});
        rd(A_SRC, {24'h0, md, 7'h0});
        wr(A_SRC, 32'h0);
        $display("ring mode %0d done", md);
    endtask

    // Read data and response are taken at the data phase's ready edge
    always @(posedge mclk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            exp_v = exp_q.pop_front();
            cmp("hrdata", exp_v, hrdata);
            cmp("hresp", 32'h0, {31'h0, hresp});
        end
        if (hreadyout === 1'b1) begin
            rd_ph = hsel && htrans[1] && !hwrite;
        end
    end

    always @(posedge mclk) begin
        progress_in <= 1'($random(seed));
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("unexpected run length exp done got timeout");
        end_sim();
    end

    initial begin
        seed = 78840;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ev = 8'h00;
        n_errors = 0;
        n_checks = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(A_CTL, 32'h0);
        rd(A_MASK, 32'h0);
        rd(A_SRC, 32'h0);
        rd(A_HOOK, 32'h0);
        r = $random(seed);
        wr(A_BAD, r);
        rd(A_BAD, 32'h0);
        wr(A_MASK, r);
        rd(A_MASK, {24'h0, r[7:0]});
        $display("reset and map done");
        // Reserved bits 5 and 3 are written high and must read 0
        for (int v = 0; v < 4; v++) begin
            wr(A_CTL, 32'h28 | v);
            rd(A_CTL, v);
            #1 cmp("paths", v, {30'h0, hyb, rx});
        end
        for (int k = 0; k < 16; k++) begin
            @(posedge mclk);
            m = {31'h0, progress_in};
            #1 cmp("progress pin", m, {31'h0, pin});
        end
        $display("paths and progress done");
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 2; j++) begin
                pol = i[0];
                m = 32'h1 << i;
                wr(A_CTL, {24'h0, 1'b1, pol, 6'h0});
                wr(A_MASK, j ? m : ~m);
                ev[i] <= 1'b1;
                repeat (5) @(posedge mclk);
                #1 cmp("irq pin", j ? pol : !pol, pin);
                rd(A_SRC, m);
                ev[i] <= 1'b0;
                repeat (5) @(posedge mclk);
                wr(A_SRC, 32'h0);
                rd(A_SRC, 32'h0);
                #1 cmp("idle pin", !pol, pin);
            end
        end
        $display("source masks done");
        ring(1'b0);
        ring(1'b1);
        wr(A_HOOK, 32'h1);
        rd(A_HOOK, 32'h1);
        wr(A_CTL, 32'h10);
        wr(A_CTL, 32'h0);
        rd(A_CTL, 32'h10);
        // Accesses closer than the timeout keep the line off-hook
        repeat (4) begin
            repeat (12) @(posedge mclk);
            rd(A_HOOK, 32'h1);
        end
        #1 cmp("offhook kept", 32'h1, {31'h0, oh});
        repeat (30) @(posedge mclk);
        #1 cmp("offhook timeout", 32'h0, {31'h0, oh});
        rd(A_HOOK, 32'h0);
        wr(A_HOOK, 32'h1);
        @(posedge mclk);
        #1 cmp("offhook again", 32'h1, {31'h0, oh});
        $display("watchdog done");
        // Only a hardware reset in mid-run may drop the enable
        wr(A_CTL, 32'h3);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(A_CTL, 32'h0);
        rd(A_HOOK, 32'h0);
        #1 cmp("reset outputs", 32'h0, {29'h0, hyb, rx, oh});
        $display("hardware reset done");
        end_sim();
    end
endmodule
